/* common/fmd_pkg.sv */
// Constants for the extended diagnostic record in frequency-measurement mode.
// Assumes a single 100 MHz clock and byte-wide record readout.
package fmd_pkg;
    localparam int REC_BYTES = 16;
    localparam int BASIC_BYTES = 4;
    localparam int IDX_W = 4;
    localparam int NUM_DIN = 16;
    localparam int NUM_FREQ = 3;
    localparam int NUM_GRP = 4;
    // Byte indices
    localparam logic [3:0] B_STAT = 4'h0;
    localparam logic [3:0] B_CLASS = 4'h1;
    localparam logic [3:0] B_CTYPE = 4'h4;
    localparam logic [3:0] B_BITS = 4'h5;
    localparam logic [3:0] B_CHANS = 4'h6;
    localparam logic [3:0] B_ERR = 4'h7;
    localparam logic [3:0] B_LOST0 = 4'h8;
    localparam logic [3:0] B_EOI0 = 4'hc;
    localparam logic [3:0] B_LAST = 4'hf;
    // Field values
    localparam logic [6:0] CT_DIN = 7'h70;
    localparam logic [6:0] CT_AIN = 7'h71;
    localparam logic [6:0] CT_DOUT = 7'h72;
    localparam logic [6:0] CT_AOUT = 7'h73;
    localparam logic [6:0] CT_AIO = 7'h74;
    localparam logic [7:0] DIAG_BITS = 8'h08;
    localparam logic [7:0] NUM_CHANS = 8'h08;
    localparam logic [3:0] CLS_DIG = 4'hf;
    localparam logic [3:0] CLS_ANA = 4'h5;
    localparam int ST_FAIL = 0;
    localparam int ST_EXT = 2;
    localparam int ST_CHAN = 3;
    localparam int CLS_INFO = 4;
endpackage

/* common/fmd_flag_if.sv */
// Sticky flag bundle between the top and its flag store.
// Assumes one clock domain.
`timescale 1ns/1ps
interface fmd_flag_if;
    logic [15:0] din_lost;
    logic [2:0] eoi_lost;
    logic [3:0] grp_err;
    logic [2:0] freq_err;
    logic fail;
    logic ext_err;
    modport store (output din_lost, eoi_lost, grp_err, freq_err, fail, ext_err);
    modport user (input din_lost, eoi_lost, grp_err, freq_err, fail, ext_err);
endinterface

/* hw/fmd_flag_store.sv */
// Sticky diagnostic flags; set pulses and a clear pulse.
// Assumes set inputs come from logic on ref_clk_in.
`timescale 1ns/1ps
module fmd_flag_store
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [15:0] din_lost_set_in,
    input wire logic [2:0] eoi_lost_set_in,
    input wire logic [3:0] grp_err_set_in,
    input wire logic [2:0] freq_err_set_in,
    input wire logic fail_set_in,
    input wire logic ext_err_set_in,
    input wire logic clear_in,
    fmd_flag_if.store flags
);
    logic [27:0] flag_q;
    logic [27:0] flag_d;
    logic [27:0] set_w;

    assign set_w = {ext_err_set_in, fail_set_in, freq_err_set_in, grp_err_set_in,
        eoi_lost_set_in, din_lost_set_in};

    // Set wins over a same-cycle clear
    always_comb
    begin
        flag_d = (clear_in ? 28'h0000000 : flag_q) | set_w;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
            flag_q <= 28'h0000000;
        else
            flag_q <= flag_d;
    end

    assign flags.din_lost = flag_q[15:0];
    assign flags.eoi_lost = flag_q[18:16];
    assign flags.grp_err = flag_q[22:19];
    assign flags.freq_err = flag_q[25:23];
    assign flags.fail = flag_q[26];
    assign flags.ext_err = flag_q[27];
endmodule

/* hw/fmd_record.sv */
// Extended diagnostic record builder, frequency-measurement mode.
// Assumes event pulses synchronous to ref_clk_in; byte read by index.
// Operation
// - The record is four basic bytes plus twelve module bytes, sixteen in all.
// - Byte 4 bits 6..0 carry the channel type, digital input in this mode.
// - Byte 4 bit 7 says whether more channel types follow.
// - Byte 5 reads eight diagnostic bits per channel.
// - Byte 6 reads eight channels.
// - Byte 7 bits 0..3 flag errors in the four input groups in order.
// - Byte 7 bits 4..6 flag errors in measurement channels 0..2, bit 7 reserved.
// - Bytes 8..11 put lost-interrupt flags of four inputs on even bits, odd bits zero.
// - Bytes 12..14 bit 0 flag a lost end-of-integration interrupt, other bits zero.
// - Byte 0 shows module failure, external error and channel error on bits 0, 2, 3.
// - Byte 1 holds the module class in bits 3..0 and channel info present in bit 4.
`timescale 1ns/1ps
module fmd_record
#(
    parameter logic [6:0] CHAN_TYPE = fmd_pkg::CT_DIN,
    parameter bit MORE_TYPES = 1'b0,
    parameter logic [3:0] MOD_CLASS = fmd_pkg::CLS_DIG
)
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [15:0] din_lost_set_in,
    input wire logic [2:0] eoi_lost_set_in,
    input wire logic [3:0] grp_err_set_in,
    input wire logic [2:0] freq_err_set_in,
    input wire logic fail_set_in,
    input wire logic ext_err_set_in,
    input wire logic clear_in,
    input wire logic rd_en_in,
    input wire logic [fmd_pkg::IDX_W-1:0] rd_idx_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic diag_active_out
);
    import fmd_pkg::*;

    // Byte positions past the first of each run
    localparam logic [3:0] B_LOST1 = B_LOST0 + 4'h1;
    localparam logic [3:0] B_LOST2 = B_LOST0 + 4'h2;
    localparam logic [3:0] B_LOST3 = B_LOST0 + 4'h3;
    localparam logic [3:0] B_EOI1 = B_EOI0 + 4'h1;
    localparam logic [3:0] B_EOI2 = B_EOI0 + 4'h2;

    // Parameter checks; the byte map below is fixed
    if (CHAN_TYPE < CT_DIN || CHAN_TYPE > CT_AIO)
    begin
        $error("channel type code out of range");
    end
    if (MOD_CLASS != CLS_DIG && MOD_CLASS != CLS_ANA)
    begin
        $error("module class must be digital or analog");
    end
    if (REC_BYTES != (1 << IDX_W))
    begin
        $error("record length must fill the byte index");
    end
    if ((1 << IDX_W) <= int'(B_LAST))
    begin
        $error("byte index too narrow for the last byte");
    end
    if (NUM_DIN != NUM_GRP * 4)
    begin
        $error("each input group holds four inputs");
    end
    if (int'(B_EOI0) != int'(B_LOST0) + NUM_GRP || int'(B_LAST) != int'(B_EOI0) + NUM_FREQ)
    begin
        $error("lost-interrupt bytes must follow one another");
    end
    if (int'(B_CTYPE) != BASIC_BYTES)
    begin
        $error("module bytes must follow the basic record");
    end

    fmd_flag_if flags();

    fmd_flag_store u_store
    (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .din_lost_set_in(din_lost_set_in),
        .eoi_lost_set_in(eoi_lost_set_in),
        .grp_err_set_in(grp_err_set_in),
        .freq_err_set_in(freq_err_set_in),
        .fail_set_in(fail_set_in),
        .ext_err_set_in(ext_err_set_in),
        .clear_in(clear_in),
        .flags(flags)
    );

    // Basic record byte 0
    function automatic logic [7:0] status_byte(input logic fail, input logic ext, input logic chan);
        status_byte = 8'h00;
        status_byte[ST_FAIL] = fail;
        status_byte[ST_EXT] = ext;
        status_byte[ST_CHAN] = chan;
    endfunction

    // Channel info is always present here
    function automatic logic [7:0] class_byte(input logic [3:0] cls);
        class_byte = {4'h0, cls};
        class_byte[CLS_INFO] = 1'b1;
    endfunction

    function automatic logic [7:0] type_byte(input logic more, input logic [6:0] code);
        type_byte = {more, code};
    endfunction

    // Bit 7 stays reserved as zero
    function automatic logic [7:0] err_byte(input logic [3:0] grp, input logic [2:0] meter);
        err_byte = {1'b0, meter, grp};
    endfunction

    // Spread four flags onto even bits
    function automatic logic [7:0] even_spread(input logic [3:0] f);
        even_spread = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
    endfunction

    function automatic logic [7:0] bit0_byte(input logic f);
        bit0_byte = {7'h00, f};
    endfunction

    // Record bytes built from live flags
    logic lost_any;
    logic chan_err;
    logic [7:0] stat_w;
    logic [7:0] class_w;
    logic [7:0] type_w;
    logic [7:0] err_w;
    logic [7:0] lost_w [NUM_GRP];
    logic [7:0] eoi_w [NUM_FREQ];
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic valid_q;
    logic valid_d;

    assign lost_any = |{flags.din_lost, flags.eoi_lost};
    assign chan_err = lost_any | (|flags.grp_err) | (|flags.freq_err);
    assign stat_w = status_byte(flags.fail, flags.ext_err, chan_err);
    assign class_w = class_byte(MOD_CLASS);
    assign type_w = type_byte(MORE_TYPES, CHAN_TYPE);
    assign err_w = err_byte(flags.grp_err, flags.freq_err);

    for (genvar g = 0; g < NUM_GRP; g++)
    begin : g_lost
        assign lost_w[g] = even_spread(flags.din_lost[4 * g +: 4]);
    end

    for (genvar k = 0; k < NUM_FREQ; k++)
    begin : g_eoi
        assign eoi_w[k] = bit0_byte(flags.eoi_lost[k]);
    end

    // Reads are never refused, so every request answers
    always_comb
    begin
        valid_d = rd_en_in;
    end

    // Data holds between reads so a slow reader still sees it
    always_comb
    begin
        data_d = data_q;
        if (rd_en_in)
        begin
            case (rd_idx_in)
                B_STAT: data_d = stat_w;
                B_CLASS: data_d = class_w;
                B_CTYPE: data_d = type_w;
                B_BITS: data_d = DIAG_BITS;
                B_CHANS: data_d = NUM_CHANS;
                B_ERR: data_d = err_w;
                B_LOST0: data_d = lost_w[0];
                B_LOST1: data_d = lost_w[1];
                B_LOST2: data_d = lost_w[2];
                B_LOST3: data_d = lost_w[3];
                B_EOI0: data_d = eoi_w[0];
                B_EOI1: data_d = eoi_w[1];
                B_EOI2: data_d = eoi_w[2];
                B_LAST: data_d = 8'h00;
                // Basic bytes 2 and 3 are fixed zero
                default: data_d = 8'h00;
            endcase
        end
    end

    // Reset also clears the last byte shown
    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
            data_q <= 8'h00;
        else
            data_q <= data_d;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
            valid_q <= 1'b0;
        else
            valid_q <= valid_d;
    end

    assign rd_data_out = data_q;
    assign rd_valid_out = valid_q;
    // Any flag raised means a diagnostic is pending
    assign diag_active_out = chan_err | flags.fail | flags.ext_err;
endmodule

/* test/fmd_record_chk.sv */
// Port assertions for the record builder.
// Bound onto fmd_record; one clock domain.
`timescale 1ns/1ps
module fmd_record_chk
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic rd_en_in,
    input wire logic [3:0] rd_idx_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    wire rd = rd_en_in;
    wire [3:0] ix = rd_idx_in;
    property p_valid; rd |=> rd_valid_out; endproperty
    a_valid: assert property (p_valid) else $error("no valid");
    property p_idle; !rd |=> !rd_valid_out; endproperty
    a_idle: assert property (p_idle) else $error("stray valid");
    property p_type; rd && ix == 4'h4 |=> rd_data_out == 8'h70; endproperty
    a_type: assert property (p_type) else $error("bad type");
    property p_cnt; rd && ix inside {4'h5, 4'h6} |=> rd_data_out == 8'h08; endproperty
    a_cnt: assert property (p_cnt) else $error("bad count");
    property p_class; rd && ix == 4'h1 |=> rd_data_out == 8'h1f; endproperty
    a_class: assert property (p_class) else $error("bad class");
    property p_zero; rd && ix inside {4'h2, 4'h3, 4'hf} |=> rd_data_out == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("not zero");
    property p_odd; rd && ix inside {[4'h8:4'hb]} |=> (rd_data_out & 8'haa) == 8'h00; endproperty
    a_odd: assert property (p_odd) else $error("odd bit set");
    property p_eoi; rd && ix inside {[4'hc:4'he]} |=> rd_data_out[7:1] == 7'h00; endproperty
    a_eoi: assert property (p_eoi) else $error("high bits set");
endmodule
bind fmd_record fmd_record_chk i_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .rd_en_in(rd_en_in),
    .rd_idx_in(rd_idx_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out));

/* test/fmd_reader.sv */
// Controller side: reads one record byte per call.
// Drives at the falling edge of ref_clk_in.
`timescale 1ns/1ps
module fmd_reader
(
    input wire logic ref_clk_in,
    output logic rd_en_out,
    output logic [3:0] rd_idx_out
);
    initial rd_en_out = 1'b0;
    initial rd_idx_out = 4'h0;
    task automatic get_byte(input logic [3:0] i);
        @(negedge ref_clk_in);
        rd_en_out = 1'b1;
        rd_idx_out = i;
        @(negedge ref_clk_in);
        rd_en_out = 1'b0;
        // Inverted idle index, so a stale one never helps
        rd_idx_out = ~i;
    endtask
endmodule

/* test/fmd_record_tb.sv */
// Bench for the record builder.
// Reads go through fmd_reader; set pulses from here.
`timescale 1ns/1ps
module fmd_record_tb;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic clr = 1'b0;
    logic [27:0] s = '0;
    logic en;
    logic [3:0] ix;
    logic [7:0] d;
    logic act;
    logic vld;
    int miscompares = 0;
    int comparisons = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    fmd_record i_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .din_lost_set_in(s[15:0]),
        .eoi_lost_set_in(s[18:16]), .grp_err_set_in(s[22:19]), .freq_err_set_in(s[25:23]),
        .fail_set_in(s[26]), .ext_err_set_in(s[27]), .clear_in(clr), .rd_en_in(en),
        .rd_idx_in(ix), .rd_data_out(d), .rd_valid_out(vld), .diag_active_out(act));
    fmd_reader i_rd (.ref_clk_in(ref_clk_in), .rd_en_out(en), .rd_idx_out(ix));
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk(input logic [3:0] i, input logic [7:0] e);
        i_rd.get_byte(i);
        cmp($sformatf("byte %0d", i), e, d);
        cmp("valid", 8'h01, {7'h0, vld});
    endtask
    // Bit 31 sets nothing, so hit(31, 1) is a bare clear
    task automatic hit(input int n, input logic c);
        @(negedge ref_clk_in);
        s = 28'h1 << n;
        clr = c;
        @(negedge ref_clk_in);
        s = '0;
        clr = 1'b0;
    endtask
    task automatic t_fixed;
        logic [7:0] e [16] = '{1: 8'h1f, 4: 8'h70, 5: 8'h08, 6: 8'h08, default: 8'h00};
        for (int k = 0; k < 16; k++)
            chk(4'(k), e[k]);
        cmp("active", 8'h00, {7'h0, act});
    endtask
    task automatic t_lost;
        for (int n = 0; n < 16; n++)
        begin
            hit(n, 1'b0);
            chk(4'(8 + n / 4), 8'h1 << (2 * (n % 4)));
            chk(4'h0, 8'h08);
            hit(31, 1'b1);
        end
    endtask
    task automatic t_err;
        for (int b = 0; b < 10; b++)
        begin
            hit(16 + b, 1'b0);
            chk(b < 3 ? 4'(12 + b) : 4'h7, b < 3 ? 8'h01 : 8'h1 << (b - 3));
            chk(4'h0, 8'h08);
            hit(31, 1'b1);
        end
    endtask
    task automatic t_base;
        hit(26, 1'b0);
        cmp("active", 8'h01, {7'h0, act});
        chk(4'h0, 8'h01);
        hit(27, 1'b1);
        chk(4'h0, 8'h04);
        @(negedge ref_clk_in);
        nrst_in = 1'b0;
        @(negedge ref_clk_in);
        nrst_in = 1'b1;
        cmp("active", 8'h00, {7'h0, act});
        chk(4'h0, 8'h00);
    endtask
    task automatic test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge ref_clk_in);
        nrst_in = 1'b1;
        t_fixed();
        t_lost();
        t_err();
        t_base();
        test_done();
    end
    initial
    begin
        #20000;
        miscompares++;
        test_done();
    end
endmodule
